/* design/ppm_consts.vh */
/*
  Constants for the power-management register bank: offsets, field positions,
  reset values. Assumes inclusion by bare name from design files.
*/
`ifndef PPM_CONSTS_VH
`define PPM_CONSTS_VH
`define PPM_OFF_PMCSR       8'h48
`define PPM_OFF_PMEXT       8'h4a
`define PPM_OFF_PHYCTL      8'hec
`define PPM_PMCSR_FLAG_BIT  15
`define PPM_PMCSR_EN_BIT    8
`define PPM_PMCSR_LVL_LSB   0
`define PPM_PHY_ROUTE_BIT   7
`define PPM_PHY_COMPL_BIT   3
`define PPM_PMCSR_RST       16'h0000
`define PPM_PMEXT_RST       16'h0000
`define PPM_PHYCTL_RST      32'h00000008
`define PPM_EE_PHY_BYTE     8'h16
`endif

/* design/ppm_sticky_bit.v */
/*
  One control bit with a hard reset and an optional soft reset.
  Assumes one clock; hard reset is asynchronous active low.
*/
`timescale 1ns/1ps
`default_nettype none
module ppm_sticky_bit #(
  parameter RST_VAL = 1'b0
) (
  // Clock and resets
  input  wire clk,
  input  wire hard_rst_n,
  input  wire soft_clr,
  // Update
  input  wire load,
  input  wire din,
  // State
  output reg  q
);
  always @(posedge clk or negedge hard_rst_n) begin
    if (!hard_rst_n) begin
      q <= RST_VAL;
    end else if (load) begin
      q <= din;
    end else if (soft_clr) begin
      q <= RST_VAL;
    end
  end
endmodule
`default_nettype wire

/* design/ppm_regs.v */
/*
  Power-management control/status, extension and PHY control registers,
  reached by configuration reads and writes with byte enables.
  Assumes synchronous inputs; WAKE_EVENT pulses when the function wants to
  signal a wake; EE_LOAD strobes once per serial EEPROM byte 16h.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ppm_consts.vh"
////////////////////////////////////////////////////////////////////////////////
// Contract
// [RULE_01] Control/status kept across D3hot-to-D0 reset
// [RULE_02] Wake flag set on any wake event
// [RULE_03] Write one clears flag, releases wake
// [RULE_04] Measurement scale and select read zero
// [RULE_05] Wake output only while enable set
// [RULE_06] Enable resets to zero unless sticky
// [RULE_07] Two-bit level field holds D0..D3
// [RULE_08] Bits 7..2 of control/status read zero
// [RULE_09] Marked bits cleared only by hard reset
// [RULE_10] Extension register reads all zero
// [RULE_11] Route bit steers cable signal out
// [RULE_12] EEPROM byte bit 7 loads route
// [RULE_13] Compliance bit defaults to one
// [RULE_14] PHY control bits 31..8 read zero
// [RULE_15] EEPROM reserved bits must be zero
// [RULE_16] Unpowered-wake capability selects sticky enable
// [RULE_17] Wake output low when flag and enable
module ppm_regs (
  // Clock and resets
  input  wire        MCLK,
  input  wire        ARST_N,
  input  wire        D3_EXIT_RST,
  // Configuration access
  input  wire        CFG_WR,
  input  wire        CFG_RD,
  input  wire [7:0]  CFG_ADDR,
  input  wire [3:0]  CFG_BE,
  input  wire [31:0] CFG_WDATA,
  output reg  [31:0] CFG_RDATA,
  // Capability and events
  input  wire        WAKE_FROM_UNPOWERED_CAP,
  input  wire        WAKE_EVENT,
  output wire        WAKE_N,
  output wire [1:0]  DEVICE_SLEEP_LEVEL,
  // EEPROM load
  input  wire        EE_LOAD,
  input  wire [7:0]  EE_DATA,
  // PHY routing
  input  wire        CABLE_NOT_ACTIVE_IN,
  output reg         CABLE_NOT_ACTIVE
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset words and address decode

  localparam [15:0] PM_RST_WORD  = `PPM_PMCSR_RST;
  localparam [15:0] EXT_RST_WORD = `PPM_PMEXT_RST;
  localparam [31:0] PHY_RST_WORD = `PPM_PHYCTL_RST;

  // Only the low PHY byte is stored; the upper bits are hardwired zero
  localparam [7:0]  PHY_RST_BYTE = PHY_RST_WORD[7:0];

  wire [7:0]  word_addr;
  wire        hit_pm;
  wire        hit_phy;
  wire        wr_pm_lo;
  wire        wr_pm_hi;
  wire        wr_phy;
  wire        clr_req;

  assign word_addr = {CFG_ADDR[7:2], 2'b00};
  assign hit_pm    = (word_addr == `PPM_OFF_PMCSR);
  assign hit_phy   = (word_addr == `PPM_OFF_PHYCTL);
  assign wr_pm_lo  = CFG_WR && hit_pm && CFG_BE[0];
  assign wr_pm_hi  = CFG_WR && hit_pm && CFG_BE[1];
  assign wr_phy    = CFG_WR && hit_phy && CFG_BE[0];

  // Only a one in the flag position clears; a zero is ignored (see [RULE_03])
  assign clr_req   = wr_pm_hi && CFG_WDATA[`PPM_PMCSR_FLAG_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // State and next values

  reg         wake_event_flag_ff;
  reg         nxt_wake_event_flag;
  reg  [1:0]  device_sleep_level_ff;
  reg  [1:0]  nxt_device_sleep_level;
  reg  [7:0]  phy_ctl_ff;
  reg  [7:0]  nxt_phy_ctl;
  reg         nxt_cable_not_active;
  reg  [15:0] pm_word;
  reg  [31:0] nxt_cfg_rdata;
  wire        wake_assert_enable;
  wire        enable_soft_clr;
  wire        wake_drive;

  ////////////////////////////////////////////////////////////////////////////
  // Wake-event flag

  // Set beats clear so a coincident event is never lost (see [RULE_02]) (see [RULE_03])
  always @* begin
    nxt_wake_event_flag = wake_event_flag_ff;
    if (WAKE_EVENT) begin
      nxt_wake_event_flag = 1'b1;
    end else if (clr_req) begin
      nxt_wake_event_flag = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power level field

  always @* begin
    nxt_device_sleep_level = device_sleep_level_ff;
    if (wr_pm_lo) begin
      nxt_device_sleep_level = CFG_WDATA[`PPM_PMCSR_LVL_LSB +: 2]; // see [RULE_07]
    end
  end

  // Hard reset alone clears these; the D3 exit reset is ignored (see [RULE_01]) (see [RULE_09])
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wake_event_flag_ff    <= PM_RST_WORD[`PPM_PMCSR_FLAG_BIT];
      device_sleep_level_ff <= PM_RST_WORD[`PPM_PMCSR_LVL_LSB +: 2];
    end else begin
      wake_event_flag_ff    <= nxt_wake_event_flag;
      device_sleep_level_ff <= nxt_device_sleep_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake-assert enable

  // D3 exit reset clears the enable unless it is sticky (see [RULE_06]) (see [RULE_16])
  assign enable_soft_clr = D3_EXIT_RST && !WAKE_FROM_UNPOWERED_CAP;

  ppm_sticky_bit #(
    .RST_VAL (PM_RST_WORD[`PPM_PMCSR_EN_BIT])
  ) u_enable (
    .clk        (MCLK),
    .hard_rst_n (ARST_N),
    .soft_clr   (enable_soft_clr),
    .load       (wr_pm_hi),
    .din        (CFG_WDATA[`PPM_PMCSR_EN_BIT]),
    .q          (wake_assert_enable)
  );

  ////////////////////////////////////////////////////////////////////////////
  // PHY control byte

  // EEPROM byte loads whole; reserved bits rely on a clean image (see [RULE_12])
  always @* begin
    nxt_phy_ctl = phy_ctl_ff;
    if (EE_LOAD) begin
      nxt_phy_ctl = EE_DATA;
    end else if (wr_phy) begin
      nxt_phy_ctl[`PPM_PHY_ROUTE_BIT] = CFG_WDATA[`PPM_PHY_ROUTE_BIT];
    end
  end

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      phy_ctl_ff <= PHY_RST_BYTE; // see [RULE_13]
    end else begin
      phy_ctl_ff <= nxt_phy_ctl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake and level outputs

  // Open-drain style wake output (see [RULE_05]) (see [RULE_17])
  assign wake_drive         = wake_event_flag_ff & wake_assert_enable;
  assign WAKE_N             = ~wake_drive;
  assign DEVICE_SLEEP_LEVEL = device_sleep_level_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Cable-activity output

  // Registered so the terminal never glitches while the route bit changes
  always @* begin
    nxt_cable_not_active = 1'b0;
    if (phy_ctl_ff[`PPM_PHY_ROUTE_BIT]) begin
      nxt_cable_not_active = CABLE_NOT_ACTIVE_IN; // see [RULE_11]
    end
  end

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CABLE_NOT_ACTIVE <= 1'b0;
    end else begin
      CABLE_NOT_ACTIVE <= nxt_cable_not_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Scale, select and bits 7..2 stay zero (see [RULE_04]) (see [RULE_08])
  always @* begin
    pm_word                          = 16'h0000;
    pm_word[`PPM_PMCSR_FLAG_BIT]     = wake_event_flag_ff;
    pm_word[`PPM_PMCSR_EN_BIT]       = wake_assert_enable;
    pm_word[`PPM_PMCSR_LVL_LSB +: 2] = device_sleep_level_ff;
  end

  // Read data holds until the next read; unmapped words read zero
  always @* begin
    nxt_cfg_rdata = CFG_RDATA;
    if (CFG_RD) begin
      if (hit_pm) begin
        // Upper half is the extension register, always zero (see [RULE_10])
        nxt_cfg_rdata = {EXT_RST_WORD, pm_word};
      end else if (hit_phy) begin
        nxt_cfg_rdata = {24'h000000, phy_ctl_ff}; // see [RULE_14]
      end else begin
        nxt_cfg_rdata = 32'h00000000;
      end
    end
  end

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CFG_RDATA <= 32'h00000000;
    end else begin
      CFG_RDATA <= nxt_cfg_rdata;
    end
  end

endmodule
`default_nettype wire

/* verification/ppm_ee_model.sv */
/* Serial EEPROM byte source for the PHY control byte.
   Assumes the bench raises go for one cycle to request a load. */
`timescale 1ns/1ps
`default_nettype none
module ppm_ee_model (
  // Control
  input  wire logic       clk,
  input  wire logic       go,
  // Byte out
  output var  logic       load = 1'b0,
  output var  logic [7:0] data = 8'h77
);
  localparam logic [7:0] IMG = 8'h88;
  // Idle bus shows the inverse so a stale byte is never taken as valid
  always @(posedge clk) begin
    load <= go;
    data <= go ? IMG : ~IMG;
  end
endmodule
`default_nettype wire

/* verification/ppm_props.sv */
/* Port checker for ppm_regs. Assumes it is bound to ppm_regs. */
`timescale 1ns/1ps
`default_nettype none
module ppm_props (
  // Clock, resets, access
  input wire logic MCLK, ARST_N, D3_EXIT_RST, CFG_WR, CFG_RD,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [3:0] CFG_BE,
  input wire logic [31:0] CFG_WDATA, CFG_RDATA,
  // Events and outputs
  input wire logic WAKE_FROM_UNPOWERED_CAP, WAKE_EVENT, WAKE_N,
  input wire logic CABLE_NOT_ACTIVE_IN, CABLE_NOT_ACTIVE,
  input wire logic [1:0] DEVICE_SLEEP_LEVEL
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  wire logic pw = CFG_WR && CFG_ADDR == 8'h48;
  wire logic pr = CFG_RD && CFG_ADDR == 8'h48;
  sequence en_s; pw && CFG_BE[1] && CFG_WDATA[8] && !CFG_WDATA[15]; endsequence
  sequence ev_s; WAKE_EVENT && !CFG_WR && !D3_EXIT_RST; endsequence
  rsvd_zero_a: assert property (pr |=> (CFG_RDATA & 32'hffff7efc) == 32'h0)
    else $error("reserved control bits not zero");
  phy_zero_a: assert property (CFG_RD && CFG_ADDR == 8'hec |=> CFG_RDATA[31:8] == 24'h0)
    else $error("phy upper bits not zero");
  cna_gate_a: assert property (!CABLE_NOT_ACTIVE_IN |=> !CABLE_NOT_ACTIVE)
    else $error("cable output without input");
  wake_read_a: assert property (pr && !WAKE_N |=> CFG_RDATA[15] && CFG_RDATA[8])
    else $error("wake low without flag and enable");
  clr_wake_a: assert property (pw && CFG_BE[1] && CFG_WDATA[15] && !WAKE_EVENT |=> WAKE_N)
    else $error("wake not released by clear");
  wake_set_a: assert property (en_s ##1 ev_s |=> !WAKE_N)
    else $error("wake not driven after event");
  lvl_write_a: assert property (pw && CFG_BE[0] |=> DEVICE_SLEEP_LEVEL == $past(CFG_WDATA[1:0]))
    else $error("level not written");
  d3_keep_a: assert property (D3_EXIT_RST && WAKE_FROM_UNPOWERED_CAP && !CFG_WR && !WAKE_EVENT
    |=> $stable(WAKE_N) && $stable(DEVICE_SLEEP_LEVEL)) else $error("state lost on d3 exit");
endmodule
bind ppm_regs ppm_props chk (.*);
`default_nettype wire

/* verification/test_ppm_regs.sv */
/* Bench for ppm_regs through configuration reads and writes.
   Assumes a 250 MHz MCLK and inputs driven at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module test_ppm_regs;
  logic mclk = 0, arst_n = 0, d3 = 0, wr = 0, rd = 0, cap = 0, ev = 0, go = 0, cin = 0;
  logic [7:0] addr = 8'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] wd = 32'h0;
  wire logic [31:0] rdata;
  wire logic wk_n, cable_not_active, eld;
  wire logic [1:0] lvl;
  wire logic [7:0] edat;
  int n_fail = 0, samples_checked = 0;
  always #2 mclk = ~mclk;
  ppm_ee_model ee (.clk(mclk), .go(go), .load(eld), .data(edat));
  ppm_regs uut (.MCLK(mclk), .ARST_N(arst_n), .D3_EXIT_RST(d3), .CFG_WR(wr), .CFG_RD(rd),
    .CFG_ADDR(addr), .CFG_BE(be), .CFG_WDATA(wd), .CFG_RDATA(rdata),
    .WAKE_FROM_UNPOWERED_CAP(cap), .WAKE_EVENT(ev), .WAKE_N(wk_n), .DEVICE_SLEEP_LEVEL(lvl),
    .EE_LOAD(eld), .EE_DATA(edat), .CABLE_NOT_ACTIVE_IN(cin), .CABLE_NOT_ACTIVE(cable_not_active));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrt(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge mclk); wr = 1; addr = a; be = b; wd = d;
    @(negedge mclk); wr = 0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(negedge mclk); rd = 1; addr = a;
    @(negedge mclk); rd = 0;
    chk(rdata, e);
  endtask
  task automatic print_verdict;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Run is under a hundred cycles; ten times that is a hang
  initial begin #4000; n_fail++; print_verdict; end
  initial begin
    repeat (5) @(negedge mclk);
    arst_n = 1;
    rdc(8'h48, 32'h0);
    chk({30'h0, lvl}, 32'h0);
    rdc(8'hec, 32'h8);
    rdc(8'h50, 32'h0);
    wrt(8'h48, 4'hf, 32'hffffffff);
    rdc(8'h48, 32'h103);
    chk({30'h0, lvl}, 32'h3);
    cap = 1; d3 = 1; @(negedge mclk); d3 = 0;
    rdc(8'h48, 32'h103);
    wrt(8'h48, 4'h2, 32'h100); ev = 1; @(negedge mclk); ev = 0;
    chk({31'h0, wk_n}, 32'h0);
    wrt(8'h48, 4'h2, 32'h0);
    chk({31'h0, wk_n}, 32'h1);
    rdc(8'h48, 32'h8003);
    wrt(8'h48, 4'h2, 32'h8100);
    chk({31'h0, wk_n}, 32'h1);
    cap = 0; d3 = 1; @(negedge mclk); d3 = 0;
    rdc(8'h48, 32'h3);
    ev = 1; @(negedge mclk); ev = 0;
    chk({31'h0, wk_n}, 32'h1);
    rdc(8'h48, 32'h8003);
    $display("power tests done");
    go = 1; @(negedge mclk); go = 0; cin = 1; repeat (2) @(negedge mclk);
    chk({31'h0, cable_not_active}, 32'h1);
    rdc(8'hec, 32'h88);
    wrt(8'hec, 4'hf, 32'hffffff7f); @(negedge mclk);
    chk({31'h0, cable_not_active}, 32'h0);
    rdc(8'hec, 32'h8);
    arst_n = 0; @(negedge mclk); arst_n = 1;
    rdc(8'h48, 32'h0);
    chk({30'h0, lvl}, 32'h0);
    $display("phy and reset tests done");
    print_verdict;
  end
endmodule
`default_nettype wire
